//--- core/dtec_defines.svh
// register indices, field positions, reset values and counts of the dual timer
`ifndef DTEC_DEFINES_SVH
`define DTEC_DEFINES_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define DTEC_ADDR_W        18
`define DTEC_IDX_MODE_CH0  16'hFF70
`define DTEC_IDX_CSEL_CH0  16'hFF71
`define DTEC_IDX_CMP_CH0   16'hFF72
`define DTEC_IDX_CNT_CH0   16'hFF73
`define DTEC_IDX_MODE_CH1  16'hFF78
`define DTEC_IDX_CSEL_CH1  16'hFF79
`define DTEC_IDX_CMP_CH1   16'hFF7A
`define DTEC_IDX_CNT_CH1   16'hFF7B
`define DTEC_IDX_IRQ_STAT  16'hFF7C
`define DTEC_IDX_IRQ_MASK  16'hFF7D

// ==========================================================================
// mode control field positions
`define DTEC_MC_PIN_EN     0
`define DTEC_MC_TGL        1
`define DTEC_MC_CLR        2
`define DTEC_MC_SET        3
`define DTEC_MC_CASC       4
`define DTEC_MC_PWM        6
`define DTEC_MC_EN         7
`define DTEC_CS_MSB        2

// ==========================================================================
// reset values
`define DTEC_RST_CSEL      3'h0
`define DTEC_RST_CMP       8'h00
`define DTEC_RST_MASK      2'h0

// ==========================================================================
// prescaler and counter figures
`define DTEC_PRE_W         11
`define DTEC_CH0_SHIFT     0
`define DTEC_CH1_SHIFT     1
`define DTEC_SEL_FIRST_DIV 3'h2
`define DTEC_CNT_MAX       8'hFF

`endif

//--- core/dtec_pkg.sv
// shared types of the dual 8-bit timer/event counter
`include "dtec_defines.svh"
package dtec_pkg;

  // stored mode control bits of one channel
  typedef struct packed {
    logic count_enable;
    logic pwm_mode_select;
    logic cascade_select;
    logic toggle_or_polarity_select;
    logic output_pin_enable;
  } dtec_mode_s;

  // prescaler state of one channel
  typedef struct packed {
    logic [`DTEC_PRE_W-1:0] pre;
  } dtec_pre_s;

  // apb request as seen by the slave
  typedef struct packed {
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [`DTEC_ADDR_W-1:0] paddr;
    logic [31:0]             pwdata;
    logic [3:0]              pstrb;
  } dtec_apb_req_s;

  // whole state of the top module
  typedef struct packed {
    logic [1:0][2:0] clock_select;
    dtec_mode_s [1:0] mode;
    logic [1:0][7:0] compare_value;
    logic [1:0][7:0] counter_value;
    logic [1:0]      out_ff;
    logic [1:0]      irq_stat;
    logic [1:0]      irq_mask;
    logic [1:0][2:0] ev_sh;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            irq;
    logic [1:0]      pin;
    logic [1:0]      pin_drive;
  } dtec_state_s;

endpackage

//--- core/dtec_prescaler.sv
// prescaler and count source selector of one timer channel
`timescale 1ns/10ps
`include "dtec_defines.svh"
module dtec_prescaler #(
  parameter int unsigned BASE_SHIFT = `DTEC_CH0_SHIFT
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // control
  input  wire logic       i_run,
  input  wire logic [2:0] i_sel,
  // synchronised event pin edges
  input  wire logic       i_ev_fall,
  input  wire logic       i_ev_rise,
  // count pulse
  output logic            o_tick
);

  dtec_pkg::dtec_pre_s     s_r;
  dtec_pkg::dtec_pre_s     s_nxt;
  logic [3:0]              shift;
  logic [`DTEC_PRE_W-1:0]  mask;

  // ========================================================================
  // divider: each code doubles the ratio twice, so the shift steps by two
  always_comb begin
    shift = 4'(BASE_SHIFT) + {i_sel - `DTEC_SEL_FIRST_DIV, 1'b0};
    mask  = ~({`DTEC_PRE_W{1'b1}} << shift);
    s_nxt = s_r;
    // a stopped channel holds its prescaler at zero
    s_nxt.pre = i_run ? s_r.pre + 11'h001 : '0;
    case (i_sel)
      3'h0:    o_tick = i_run & i_ev_fall;
      3'h1:    o_tick = i_run & i_ev_rise;
      default: o_tick = i_run & ((s_r.pre & mask) == mask);
    endcase
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_full_rate_tick: assert property (
    (BASE_SHIFT == 0 && i_run && i_sel == 3'h2) |-> o_tick)
    else $error("undivided clock gave no tick");

  a_half_rate_tick: assert property (
    (BASE_SHIFT == 1 && i_run && i_sel == 3'h2 && o_tick) |=> (!o_tick || $changed(i_sel)))
    else $error("half rate source ticked twice in a row");

  a_edge_source: assert property (
    (i_run && i_sel == 3'h1) |-> (o_tick == i_ev_rise))
    else $error("rising edge source mismatch");

endmodule

//--- core/dtec_top.sv
// top level of the dual 8-bit timer/event counter with apb register access
`timescale 1ns/10ps
`include "dtec_defines.svh"

// What this block does
// - channel 0 source: falling/rising pin edge, then system clock /1, /4 up to /1024
// - channel 1 source: falling/rising pin edge, then system clock /2, /8 up to /2048
// - mode bit 0 hands the timer pin to the output flip-flop
// - mode bit 1 enables toggling, or in pwm mode picks active low
// - set/clear bits force the output flip-flop; 11 is forbidden
// - set/clear bits always read back as zero
// - channel 1 mode bit 4 chains channel 1 onto channel 0 as 16-bit counter
// - mode bit 6 picks clear-on-match (0) or free running pwm (1)
// - mode bit 7 low clears the count and halts count and prescaler
// - pwm output sits at inactive level while counting is disabled
// - outside pwm mode, match interval is compare value plus one count clock periods
// - with toggling on, output flip-flop inverts at every match; in cascade only at the full 16-bit match
module dtec_top (
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  // apb slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [`DTEC_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]             i_pwdata,
  input  wire logic [3:0]              i_pstrb,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // event pins from the board
  input  wire logic                    i_event_pin_ch0,
  input  wire logic                    i_event_pin_ch1,
  // timer pins
  output logic      [1:0]              o_timer_pin,
  output logic      [1:0]              o_output_pin_enable,
  // interrupt
  output logic                         o_irq
);

  localparam logic [1:0][15:0] IDX_MODE = {`DTEC_IDX_MODE_CH1, `DTEC_IDX_MODE_CH0};
  localparam logic [1:0][15:0] IDX_CSEL = {`DTEC_IDX_CSEL_CH1, `DTEC_IDX_CSEL_CH0};
  localparam logic [1:0][15:0] IDX_CMP  = {`DTEC_IDX_CMP_CH1, `DTEC_IDX_CMP_CH0};
  localparam logic [1:0][15:0] IDX_CNT  = {`DTEC_IDX_CNT_CH1, `DTEC_IDX_CNT_CH0};

  dtec_pkg::dtec_state_s   s_r;
  dtec_pkg::dtec_state_s   s_nxt;
  dtec_pkg::dtec_apb_req_s req;
  logic [15:0]             idx;
  logic                    setup;
  logic                    wr_acc;
  logic [7:0]              wdat;
  logic [1:0]              ev_pin;
  logic [1:0]              ev_rise;
  logic [1:0]              ev_fall;
  logic [1:0]              tick;
  logic [1:0]              eq;
  logic [1:0]              step;
  logic [1:0]              match;
  logic [1:0]              hit;
  logic                    casc;
  logic                    carry0;
  logic                    m16;
  logic [31:0]             rd_data;
  logic                    rd_hit;
  logic [1:0]              pwm_act;

  // ========================================================================
  // apb request decode
  assign req    = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                    paddr: i_paddr, pwdata: i_pwdata, pstrb: i_pstrb};
  assign idx    = req.paddr[`DTEC_ADDR_W-1:2];
  assign setup  = req.psel & ~req.penable;
  // a write lands only at the access edge that sees pready high
  assign wr_acc = req.psel & req.penable & req.pwrite & s_r.pready & req.pstrb[0];
  assign wdat   = req.pwdata[7:0];
  assign ev_pin = {i_event_pin_ch1, i_event_pin_ch0};

  // ========================================================================
  // per channel edge detect, compare and prescaler
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_chan
      // edges come from the second and third flops only
      assign ev_rise[g] = s_r.ev_sh[g][1] & ~s_r.ev_sh[g][2];
      assign ev_fall[g] = ~s_r.ev_sh[g][1] & s_r.ev_sh[g][2];
      assign eq[g]      = s_r.counter_value[g] == s_r.compare_value[g];
      dtec_prescaler #(
        .BASE_SHIFT (g == 0 ? `DTEC_CH0_SHIFT : `DTEC_CH1_SHIFT)
      ) u_pre (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_run     (s_r.mode[g].count_enable),
        .i_sel     (s_r.clock_select[g]),
        .i_ev_fall (ev_fall[g]),
        .i_ev_rise (ev_rise[g]),
        .o_tick    (tick[g])
      );
    end
  endgenerate

  // ========================================================================
  // cascade: channel 1 counts on channel 0 carry, match needs both bytes
  assign casc     = s_r.mode[1].cascade_select;
  assign carry0   = tick[0] & (s_r.counter_value[0] == `DTEC_CNT_MAX);
  assign m16      = casc & s_r.mode[1].count_enable & tick[0] & eq[0] & eq[1];
  assign step[0]  = tick[0];
  assign step[1]  = casc ? carry0 & s_r.mode[1].count_enable : tick[1];
  // match at the tick seen while the count equals compare
  assign match[0] = tick[0] & eq[0];
  assign match[1] = casc ? m16 : tick[1] & eq[1];
  // in cascade only the full 16-bit match restarts and toggles
  assign hit[0]   = casc ? m16 : match[0];
  assign hit[1]   = match[1];

  // ========================================================================
  // next state
  always_comb begin
    s_nxt   = s_r;
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b0;
    pwm_act = 2'h0;
    for (int i = 0; i < 2; i++) begin
      // two flop synchroniser plus one history flop for edges
      s_nxt.ev_sh[i] = {s_r.ev_sh[i][1:0], ev_pin[i]};

      // counter: stopped clears, a match restarts outside pwm mode
      if (!s_r.mode[i].count_enable) begin
        s_nxt.counter_value[i] = 8'h00;
      end else if (hit[i] && !s_r.mode[i].pwm_mode_select) begin
        s_nxt.counter_value[i] = 8'h00;
      end else if (step[i]) begin
        s_nxt.counter_value[i] = s_r.counter_value[i] + 8'h01;
      end

      // output flip-flop toggles on match when enabled
      if (hit[i] && s_r.mode[i].toggle_or_polarity_select && !s_r.mode[i].pwm_mode_select) begin
        s_nxt.out_ff[i] = ~s_r.out_ff[i];
      end

      // mode write; software stops the counter before changing it
      if (wr_acc && idx == IDX_MODE[i]) begin
        s_nxt.mode[i].count_enable              = wdat[`DTEC_MC_EN];
        s_nxt.mode[i].pwm_mode_select           = wdat[`DTEC_MC_PWM];
        s_nxt.mode[i].cascade_select            = wdat[`DTEC_MC_CASC];
        s_nxt.mode[i].toggle_or_polarity_select = wdat[`DTEC_MC_TGL];
        s_nxt.mode[i].output_pin_enable         = wdat[`DTEC_MC_PIN_EN];
        // force after toggle so a software force beats a same cycle match
        case ({wdat[`DTEC_MC_SET], wdat[`DTEC_MC_CLR]})
          2'b01:   s_nxt.out_ff[i] = 1'b0;
          2'b10:   s_nxt.out_ff[i] = 1'b1;
          default: s_nxt.out_ff[i] = s_nxt.out_ff[i];
        endcase
      end
      // only the select field is stored, upper bits read zero
      if (wr_acc && idx == IDX_CSEL[i]) begin
        s_nxt.clock_select[i] = wdat[`DTEC_CS_MSB:0];
      end
      if (wr_acc && idx == IDX_CMP[i]) begin
        s_nxt.compare_value[i] = wdat;
      end

      // read mux
      if (idx == IDX_MODE[i]) begin
        rd_hit                 = 1'b1;
        rd_data[`DTEC_MC_EN]   = s_r.mode[i].count_enable;
        rd_data[`DTEC_MC_PWM]  = s_r.mode[i].pwm_mode_select;
        rd_data[`DTEC_MC_CASC] = s_r.mode[i].cascade_select;
        rd_data[`DTEC_MC_TGL]  = s_r.mode[i].toggle_or_polarity_select;
        rd_data[`DTEC_MC_PIN_EN] = s_r.mode[i].output_pin_enable;
        // set and clear bits are write only and stay zero here
      end
      if (idx == IDX_CSEL[i]) begin
        rd_hit = 1'b1;
        rd_data[`DTEC_CS_MSB:0] = s_r.clock_select[i];
      end
      if (idx == IDX_CMP[i]) begin
        rd_hit        = 1'b1;
        rd_data[7:0]  = s_r.compare_value[i];
      end
      if (idx == IDX_CNT[i]) begin
        rd_hit        = 1'b1;
        rd_data[7:0]  = s_r.counter_value[i];
      end
    end

    // sticky status, cleared by writing one; a new match wins over the clear
    if (wr_acc && idx == `DTEC_IDX_IRQ_STAT) begin
      s_nxt.irq_stat = s_r.irq_stat & ~wdat[1:0];
    end
    s_nxt.irq_stat = s_nxt.irq_stat | match;
    if (wr_acc && idx == `DTEC_IDX_IRQ_MASK) begin
      s_nxt.irq_mask = wdat[1:0];
    end
    if (idx == `DTEC_IDX_IRQ_STAT) begin
      rd_hit       = 1'b1;
      rd_data[1:0] = s_r.irq_stat;
    end
    if (idx == `DTEC_IDX_IRQ_MASK) begin
      rd_hit       = 1'b1;
      rd_data[1:0] = s_r.irq_mask;
    end

    // no wait state: data is captured in setup, pready rises in access
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup & ~rd_hit;
    if (setup) begin
      s_nxt.prdata = rd_data;
    end

    // pins and interrupt are computed from the next state so they line up
    for (int i = 0; i < 2; i++) begin
      // pwm active while the count is below compare, never when stopped
      pwm_act[i] = s_nxt.mode[i].count_enable &
                   (s_nxt.counter_value[i] < s_nxt.compare_value[i]);
      s_nxt.pin[i] = s_nxt.mode[i].pwm_mode_select ?
                     (pwm_act[i] ^ s_nxt.mode[i].toggle_or_polarity_select) :
                     s_nxt.out_ff[i];
      s_nxt.pin_drive[i] = s_nxt.mode[i].output_pin_enable;
    end
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  // state register; every register resets to zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_r               <= '0;
      s_r.clock_select  <= {2{`DTEC_RST_CSEL}};
      s_r.compare_value <= {2{`DTEC_RST_CMP}};
      s_r.irq_mask      <= `DTEC_RST_MASK;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // outputs straight from the state register
  assign o_prdata            = s_r.prdata;
  assign o_pready            = s_r.pready;
  assign o_pslverr           = s_r.pslverr;
  assign o_timer_pin         = s_r.pin;
  assign o_output_pin_enable = s_r.pin_drive;
  assign o_irq               = s_r.irq;

  // ========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_pin_gate: assert property (
    o_output_pin_enable == {s_r.mode[1].output_pin_enable, s_r.mode[0].output_pin_enable})
    else $error("pin ownership does not follow mode bit 0");

  a_pwm_active_lvl: assert property (
    (s_r.mode[1].pwm_mode_select && s_r.mode[1].count_enable &&
     s_r.counter_value[1] < s_r.compare_value[1])
    |-> (o_timer_pin[1] == !s_r.mode[1].toggle_or_polarity_select))
    else $error("pwm active level wrong");

  a_force_clear: assert property (
    (wr_acc && idx == IDX_MODE[0] && wdat[`DTEC_MC_SET:`DTEC_MC_CLR] == 2'b01)
    |=> !s_r.out_ff[0])
    else $error("forced clear of output flip-flop lost");

  a_force_read_zero: assert property (
    (o_pready && req.psel && req.penable && idx == IDX_MODE[1]) |-> (o_prdata[3:2] == 2'h0))
    else $error("set or clear bit read back nonzero");

  a_cascade_carry: assert property (
    (casc && s_r.mode[1].count_enable && carry0 && !m16)
    |=> (s_r.counter_value[1] == $past(s_r.counter_value[1]) + 8'h01))
    else $error("upper byte missed the carry");

  a_match_restart: assert property (
    (!casc && !s_r.mode[0].pwm_mode_select && tick[0] && eq[0])
    |=> (s_r.counter_value[0] == 8'h00 && s_r.irq_stat[0]))
    else $error("match did not restart the count");

  a_stop_clears: assert property (
    !s_r.mode[1].count_enable |=> (s_r.counter_value[1] == 8'h00))
    else $error("stopped counter not cleared");

  a_pwm_inactive: assert property (
    (s_r.mode[1].pwm_mode_select && !s_r.mode[1].count_enable)
    |-> (o_timer_pin[1] == s_r.mode[1].toggle_or_polarity_select))
    else $error("stopped pwm output not inactive");

  a_toggle_match: assert property (
    (hit[1] && s_r.mode[1].toggle_or_polarity_select && !s_r.mode[1].pwm_mode_select &&
     !(wr_acc && idx == IDX_MODE[1]))
    |=> (s_r.out_ff[1] != $past(s_r.out_ff[1])))
    else $error("output flip-flop did not invert at match");

  a_match_irq: assert property (
    (match[0] && s_r.irq_mask[0] && !(wr_acc && idx == `DTEC_IDX_IRQ_MASK))
    |=> (s_r.irq_stat[0] && o_irq))
    else $error("match did not raise the interrupt");

  a_force_set: assert property (
    (wr_acc && idx == IDX_MODE[0] && wdat[`DTEC_MC_SET:`DTEC_MC_CLR] == 2'b10)
    |=> s_r.out_ff[0])
    else $error("forced set of output flip-flop lost");

  a_force_clear_hi: assert property (
    (wr_acc && idx == IDX_MODE[1] && wdat[`DTEC_MC_SET:`DTEC_MC_CLR] == 2'b01)
    |=> !s_r.out_ff[1])
    else $error("forced clear of upper output flip-flop lost");

  a_stop_clears_lo: assert property (
    !s_r.mode[0].count_enable |=> (s_r.counter_value[0] == 8'h00))
    else $error("stopped lower counter not cleared");

  // a stopped channel must see neither its own tick nor a carry from below
  a_stop_no_tick: assert property (
    !s_r.mode[1].count_enable |-> (!tick[1] && !step[1]))
    else $error("stopped channel still counts");

  a_pwm_free_run: assert property (
    (s_r.mode[1].pwm_mode_select && step[1])
    |=> (s_r.counter_value[1] == $past(s_r.counter_value[1]) + 8'h01))
    else $error("pwm counter did not run free");

  a_clear_interval: assert property (
    (!casc && !s_r.mode[1].pwm_mode_select && tick[1] && !eq[1])
    |=> (s_r.counter_value[1] == $past(s_r.counter_value[1]) + 8'h01))
    else $error("count stepped wrongly before its match");

  a_cascade_clear: assert property (
    (m16 && !s_r.mode[0].pwm_mode_select && !s_r.mode[1].pwm_mode_select)
    |=> (s_r.counter_value[0] == 8'h00 && s_r.counter_value[1] == 8'h00))
    else $error("16-bit match did not restart both bytes");

  a_match_sticky: assert property (
    match[1] |=> s_r.irq_stat[1])
    else $error("match did not set its status bit");

  a_irq_level: assert property (
    o_irq == |(s_r.irq_stat & s_r.irq_mask))
    else $error("interrupt level does not follow status and mask");

  a_csel_upper: assert property (
    (o_pready && req.psel && req.penable && idx == IDX_CSEL[0]) |-> (o_prdata[7:3] == 5'h00))
    else $error("clock select upper bits read back nonzero");

endmodule

//--- testbench/tb_top.sv
// self-checking testbench of the dual 8-bit timer/event counter
`timescale 1ns/10ps
`include "dtec_defines.svh"
module tb_top;
  // ==========================================================================
  // design inputs, outputs and bench counters
  logic                    i_clk           = 1'b0;
  logic                    i_sys_rst       = 1'b1;
  logic                    i_psel          = 1'b0;
  logic                    i_penable       = 1'b0;
  logic                    i_pwrite        = 1'b0;
  logic [`DTEC_ADDR_W-1:0] i_paddr         = '0;
  logic [31:0]             i_pwdata        = 32'h0000_0000;
  logic [3:0]              i_pstrb         = 4'h0;
  logic                    i_event_pin_ch0 = 1'b0;
  logic                    i_event_pin_ch1 = 1'b0;
  logic [31:0]             o_prdata;
  logic                    o_pready;
  logic                    o_pslverr;
  logic [1:0]              o_timer_pin;
  logic [1:0]              o_output_pin_enable;
  logic                    o_irq;
  int                      n_mismatch      = 0;
  int                      checks_done     = 0;
  logic [15:0]             mi[2]           = '{`DTEC_IDX_MODE_CH0, `DTEC_IDX_MODE_CH1};
  logic [15:0]             ci[2]           = '{`DTEC_IDX_CSEL_CH0, `DTEC_IDX_CSEL_CH1};
  logic [15:0]             pi[2]           = '{`DTEC_IDX_CMP_CH0, `DTEC_IDX_CMP_CH1};
  logic [15:0]             allr[10]        = '{`DTEC_IDX_MODE_CH0, `DTEC_IDX_CSEL_CH0,
    `DTEC_IDX_CMP_CH0, `DTEC_IDX_CNT_CH0, `DTEC_IDX_MODE_CH1, `DTEC_IDX_CSEL_CH1,
    `DTEC_IDX_CMP_CH1, `DTEC_IDX_CNT_CH1, `DTEC_IDX_IRQ_STAT, `DTEC_IDX_IRQ_MASK};
  logic [31:0]             r;
  logic                    e;
  int                      cyc;

  // 25 MHz clock
  always #20 i_clk = ~i_clk;

  dtec_top dut_u (
    .i_clk               (i_clk),
    .i_sys_rst           (i_sys_rst),
    .i_psel              (i_psel),
    .i_penable           (i_penable),
    .i_pwrite            (i_pwrite),
    .i_paddr             (i_paddr),
    .i_pwdata            (i_pwdata),
    .i_pstrb             (i_pstrb),
    .o_prdata            (o_prdata),
    .o_pready            (o_pready),
    .o_pslverr           (o_pslverr),
    .i_event_pin_ch0     (i_event_pin_ch0),
    .i_event_pin_ch1     (i_event_pin_ch1),
    .o_timer_pin         (o_timer_pin),
    .o_output_pin_enable (o_output_pin_enable),
    .o_irq               (o_irq)
  );

  // ==========================================================================
  // shared tasks
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; pready is sampled at the rising edge, where read data is taken too
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= {idx, 2'b00};
    i_pwdata  <= {24'h000000, d};
    i_pstrb   <= st;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      n_mismatch++;
      $display("ERROR at %0t: no ready", $time);
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    // outputs launched by this edge settle before the caller looks at them
    @(negedge i_clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic        x;
    apb(1'b1, idx, d, 4'hF, q, x);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    logic        x;
    apb(1'b0, idx, 8'h00, 4'h0, q, x);
    chk(q, {24'h000000, exp});
  endtask

  // cycles between the first and second change of a timer pin; the wait up to the first is start-up
  task automatic meas(input int ch, output int c);
    logic p;
    int   n;
    n = 0;
    c = 0;
    @(negedge i_clk);
    p = o_timer_pin[ch];
    while (o_timer_pin[ch] === p && n < 20000) begin
      @(negedge i_clk);
      n++;
    end
    p = o_timer_pin[ch];
    while (o_timer_pin[ch] === p && n < 20000) begin
      @(negedge i_clk);
      n++;
      c++;
    end
  endtask

  // hold an event pin level long enough to pass the synchroniser
  task automatic pulse(input int ch, input logic lvl);
    @(posedge i_clk);
    if (ch == 0) begin
      i_event_pin_ch0 <= lvl;
    end else begin
      i_event_pin_ch1 <= lvl;
    end
    repeat (8) @(posedge i_clk);
  endtask

  // high cycles over one full free-running period of 256 ticks at half the system clock
  task automatic duty(input int ch, output int hi);
    hi = 0;
    repeat (512) begin
      @(negedge i_clk);
      if (o_timer_pin[ch] === 1'b1) hi++;
    end
  endtask

  // ==========================================================================
  // watchdog: the whole sequence needs well under 60000 cycles
  initial begin
    repeat (95000) @(posedge i_clk);
    n_mismatch++;
    close_out();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) rdc(allr[i], 8'h00);
    chk({o_irq, o_timer_pin, o_output_pin_enable}, 32'h0000_0000);
    apb(1'b0, 16'hFF74, 8'h00, 4'h0, r, e);
    chk(r, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    apb(1'b1, 16'hFF74, 8'hFF, 4'hF, r, e);
    chk(e, 1'b1);
    for (int ch = 0; ch < 2; ch++) begin
      wr(ci[ch], 8'h07);
      rdc(ci[ch], 8'h07);
      wr(ci[ch], 8'h00);
    end
    apb(1'b1, pi[0], 8'h55, 4'h0, r, e);
    rdc(pi[0], 8'h00);
    wr(`DTEC_IDX_CNT_CH0, 8'h55);
    rdc(`DTEC_IDX_CNT_CH0, 8'h00);
    // forced flip-flop levels and pin ownership
    wr(mi[0], 8'h09);
    rdc(mi[0], 8'h01);
    chk({o_output_pin_enable[0], o_timer_pin[0]}, 2'b11);
    wr(mi[0], 8'h05);
    chk(o_timer_pin[0], 1'b0);
    wr(mi[0], 8'h00);
    chk(o_output_pin_enable[0], 1'b0);
    // every prescaled source, clear-and-start with compare one, toggling
    for (int ch = 0; ch < 2; ch++) begin
      for (int code = 2; code < 8; code++) begin
        wr(mi[ch], 8'h00);
        wr(ci[ch], 8'(code));
        wr(pi[ch], 8'h01);
        wr(mi[ch], 8'h83);
        meas(ch, cyc);
        chk(32'(cyc), 32'(2 << (2 * (code - 2) + ch)));
      end
    end
    // sticky status, mask and level interrupt
    rdc(`DTEC_IDX_IRQ_STAT, 8'h03);
    chk(o_irq, 1'b0);
    wr(`DTEC_IDX_IRQ_MASK, 8'h01);
    rdc(`DTEC_IDX_IRQ_MASK, 8'h01);
    chk(o_irq, 1'b1);
    wr(mi[0], 8'h00);
    wr(mi[1], 8'h00);
    rdc(`DTEC_IDX_CNT_CH1, 8'h00);
    wr(`DTEC_IDX_IRQ_STAT, 8'h01);
    rdc(`DTEC_IDX_IRQ_STAT, 8'h02);
    chk(o_irq, 1'b0);
    wr(`DTEC_IDX_IRQ_STAT, 8'h02);
    rdc(`DTEC_IDX_IRQ_STAT, 8'h00);
    // event pin edges: rising with compare two, then falling with compare zero
    for (int ch = 0; ch < 2; ch++) begin
      wr(ci[ch], 8'h01);
      wr(pi[ch], 8'h02);
      wr(mi[ch], 8'h05);
      wr(mi[ch], 8'h83);
      pulse(ch, 1'b1);
      pulse(ch, 1'b0);
      pulse(ch, 1'b1);
      pulse(ch, 1'b0);
      chk(o_timer_pin[ch], 1'b0);
      pulse(ch, 1'b1);
      chk(o_timer_pin[ch], 1'b1);
      wr(mi[ch], 8'h00);
      wr(ci[ch], 8'h00);
      wr(pi[ch], 8'h00);
      wr(mi[ch], 8'h83);
      pulse(ch, 1'b0);
      chk(o_timer_pin[ch], 1'b0);
      pulse(ch, 1'b1);
      chk(o_timer_pin[ch], 1'b0);
      wr(mi[ch], 8'h00);
    end
    // pwm on channel 1: duty, active level and stopped level
    wr(ci[1], 8'h02);
    wr(pi[1], 8'h40);
    wr(mi[1], 8'hC1);
    duty(1, cyc);
    chk(32'(cyc), 32'd128);
    wr(mi[1], 8'h00);
    wr(mi[1], 8'hC3);
    duty(1, cyc);
    chk(32'(cyc), 32'd384);
    wr(mi[1], 8'h43);
    chk(o_timer_pin[1], 1'b1);
    wr(mi[1], 8'h41);
    chk(o_timer_pin[1], 1'b0);
    // cascade: 16-bit compare 0x0103 gives 260 clock cycles between toggles
    wr(mi[1], 8'h00);
    wr(ci[0], 8'h02);
    wr(pi[0], 8'h03);
    wr(pi[1], 8'h01);
    wr(mi[1], 8'h93);
    wr(mi[0], 8'h83);
    meas(1, cyc);
    chk(32'(cyc), 32'd260);
    close_out();
  end
endmodule
